// *** hw/pss_map.svh ***
// Register map, field reset values and timing constants of the power-state sequencer
`ifndef PSS_MAP_SVH
`define PSS_MAP_SVH
// Byte offsets on the register bus
`define PSS_OFS_CTRL 5'h00
`define PSS_OFS_KEEP 5'h04
`define PSS_OFS_STBY 5'h08
`define PSS_OFS_START 5'h0C
`define PSS_OFS_SHUT 5'h10
`define PSS_OFS_STAT 5'h14
`define PSS_OFS_FLAG 5'h18
// Reset values
`define PSS_CTRL_RST 12'h000
`define PSS_KEEP_RST 7'h00
`define PSS_STBY_RST 7'h7F
`define PSS_SLOT_RST 21'h1A_C688
// Clock rate and derived ms prescale
`define PSS_CLK_HZ 25_000_000
`define PSS_CYC_PER_MS (`PSS_CLK_HZ / 1000)
// Durations in ms
`define PSS_LONG_MS 14'h0FA0
`define PSS_RESTART_MS 14'h03E8
`define PSS_WAKE_MS 14'h03E8
`define PSS_HOLD_MS 14'h1F40
`define PSS_SLOT_MS 14'h0002
`define PSS_DB0_MS 14'h0001
`define PSS_DB1_MS 14'h0010
`define PSS_DB2_MS 14'h0020
`define PSS_DB3_MS 14'h0040
`define PSS_RLS0_MS 14'h0002
`define PSS_RLS1_MS 14'h0004
`define PSS_RLS2_MS 14'h0008
`define PSS_RLS3_MS 14'h0010
`define PSS_RLS4_MS 14'h0040
`define PSS_RLS5_MS 14'h0100
`define PSS_RLS6_MS 14'h0200
`define PSS_RLS7_MS 14'h0400
`endif

// *** hw/pss_pkg.sv ***
// Types shared by the power-state sequencer
package pss_pkg;
  typedef enum logic [3:0] {
    ST_OFF, ST_PUP, ST_RLS, ST_RUN, ST_STBY, ST_SLEEP, ST_PDN, ST_DEEP, ST_STORE
  } pss_state_t;
  typedef struct packed {
    logic deep_idle_request;
    logic storage_request;
    logic [2:0] reset_release_delay;
    logic [1:0] power_on_debounce_sel;
    logic button_reset_enable;
    logic auto_restart_enable;
    logic long_press_off_enable;
    logic power_on_trigger_style;
    logic standby_polarity_invert;
  } pss_ctrl_t;
  typedef struct packed {
    logic thermal_shutdown;
    logic thermal_release_ok;
    logic supply_above_uv;
    logic supply_below_uv_fall;
    logic charger_absent;
    logic battery_reattach;
  } pss_sense_t;
  typedef struct packed {
    logic host_released;
    logic [6:0] enables;
    logic [3:0] state;
  } pss_stat_t;
  typedef struct packed {
    logic powerdown_done;
    logic powerup_done;
  } pss_flag_t;
endpackage : pss_pkg

// *** hw/pss_sequencer.sv ***
// Power-state controller with slot sequencers and Avalon-MM registers
`timescale 1ns/1ns
`include "pss_map.svh"
module pss_sequencer
  import pss_pkg::*;
#(
  parameter int CYC_PER_MS = `PSS_CYC_PER_MS,
  parameter logic [13:0] BTN_HOLD_MS = `PSS_HOLD_MS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Avalon-MM slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Pins and supply conditions
  input wire logic power_on_input,
  input wire logic standby_input,
  input wire logic watchdog_input,
  input wire logic button_input,
  input wire pss_sense_t sense,
  // Regulator and host controls
  output logic [6:0] reg_enable,
  output logic backup_rail_on,
  output logic host_reset_n,
  output logic powerup_done_irq,
  output logic powerdown_done_irq
);
  // Refuse timing parameters the counters cannot serve
  if (CYC_PER_MS < 1 || BTN_HOLD_MS < 14'h0001) begin : g_bad_timing
    $error("pss_sequencer: bad timing parameters");
  end

  // Sequencer slot selection
  function automatic logic [6:0] slot_hits(input logic [20:0] slots, input logic [2:0] s);
    logic [6:0] m;
    m = '0;
    for (int i = 0; i < 7; i++) begin
      m[i] = (slots[3*i +: 3] == s);
    end
    return m;
  endfunction : slot_hits

  // Byte-lane merge for writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [3:0] be, input logic [31:0] d);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = d[8*b +: 8];
      end
    end
    return r;
  endfunction : merge

  // Debounce time from selector
  function automatic logic [13:0] db_ms(input logic [1:0] s);
    case (s)
      2'h0: db_ms = `PSS_DB0_MS;
      2'h1: db_ms = `PSS_DB1_MS;
      2'h2: db_ms = `PSS_DB2_MS;
      default: db_ms = `PSS_DB3_MS;
    endcase
  endfunction : db_ms

  // Host reset release delay from selector
  function automatic logic [13:0] rls_ms(input logic [2:0] s);
    case (s)
      3'h0: rls_ms = `PSS_RLS0_MS;
      3'h1: rls_ms = `PSS_RLS1_MS;
      3'h2: rls_ms = `PSS_RLS2_MS;
      3'h3: rls_ms = `PSS_RLS3_MS;
      3'h4: rls_ms = `PSS_RLS4_MS;
      3'h5: rls_ms = `PSS_RLS5_MS;
      3'h6: rls_ms = `PSS_RLS6_MS;
      default: rls_ms = `PSS_RLS7_MS;
    endcase
  endfunction : rls_ms

  // Software-visible state
  pss_ctrl_t ctrl;
  logic [6:0] sleep_keep;
  logic [6:0] stby_on;
  logic [20:0] startup_slot;
  logic [20:0] shutdown_slot;
  pss_flag_t flags;
  // Sequencing state
  pss_state_t st, st_q, dest;
  logic [6:0] tgt;
  logic [2:0] slot;
  logic [13:0] tmr;
  logic from_off, from_run, off_by_lp;
  // Input conditioning
  logic [31:0] pre;
  logic [13:0] dcnt, pon_ms, btn_ms;
  logic pon, pon_q, pon_arm, btn_q, btn_arm, chg_q;

  // Bus decode
  wire req = (avs_read | avs_write) & avs_waitrequest;
  wire wr = avs_write & ~avs_waitrequest;
  wire sel_ctrl = avs_address == `PSS_OFS_CTRL;
  wire sel_keep = avs_address == `PSS_OFS_KEEP;
  wire sel_stby = avs_address == `PSS_OFS_STBY;
  wire sel_start = avs_address == `PSS_OFS_START;
  wire sel_shut = avs_address == `PSS_OFS_SHUT;
  wire sel_stat = avs_address == `PSS_OFS_STAT;
  wire sel_flag = avs_address == `PSS_OFS_FLAG;
  wire [31:0] wctrl = merge(32'(ctrl), avs_byteenable, avs_writedata);
  wire [31:0] wkeep = merge(32'(sleep_keep), avs_byteenable, avs_writedata);
  wire [31:0] wstby = merge(32'(stby_on), avs_byteenable, avs_writedata);
  wire [31:0] wstart = merge(32'(startup_slot), avs_byteenable, avs_writedata);
  wire [31:0] wshut = merge(32'(shutdown_slot), avs_byteenable, avs_writedata);
  wire [31:0] wflag = merge(32'h0000_0000, avs_byteenable, avs_writedata);
  wire pss_stat_t stat = '{host_released: host_reset_n, enables: reg_enable, state: st};
  wire [31:0] rd_mux = sel_ctrl ? 32'(ctrl) :
                       sel_keep ? 32'(sleep_keep) :
                       sel_stby ? 32'(stby_on) :
                       sel_start ? 32'(startup_slot) :
                       sel_shut ? 32'(shutdown_slot) :
                       sel_stat ? 32'(stat) :
                       sel_flag ? 32'(flags) : 32'h0000_0000;

  // Timebase and input events
  wire tick = pre == 32'(CYC_PER_MS - 1);
  wire lvl = ~ctrl.power_on_trigger_style;
  wire stby_req = standby_input ^ ctrl.standby_polarity_invert;
  wire keep_any = |sleep_keep[5:0];
  wire pon_fall = pon_q & ~pon;
  wire pon_rise = ~pon_q & pon;
  wire pon_long = ~pon & pon_arm & (pon_ms > `PSS_LONG_MS);
  wire btn_hold = ~button_input & btn_arm & (btn_ms > BTN_HOLD_MS);
  wire btn_wake = ~button_input & btn_arm & (btn_ms > `PSS_WAKE_MS);
  wire chg_attach = chg_q & ~sense.charger_absent;
  wire entered = st != st_q;
  wire on_ok = sense.supply_above_uv & sense.thermal_release_ok;

  // Transition conditions
  wire sleep_go = lvl ? (~pon & keep_any)
                      : (pon_long & ctrl.long_press_off_enable & keep_any);
  wire lp_off = ~lvl & pon_long & ((ctrl.long_press_off_enable & ~keep_any) | (st == ST_SLEEP));
  wire off_go = sense.thermal_shutdown | ctrl.storage_request
              | (host_reset_n & ~watchdog_input)
              | sense.supply_below_uv_fall
              | (btn_hold & ctrl.button_reset_enable)
              | (lvl & ~pon & ~keep_any) | lp_off;
  wire wake = lvl ? pon : (pon_rise & (pon_ms != 14'h0000));
  wire turn_on = on_ok & (lvl ? pon
               : (pon_fall | chg_attach
                  | (off_by_lp & ctrl.auto_restart_enable & ~pon & (tmr > `PSS_RESTART_MS))));
  wire deep_go = sense.charger_absent
               & ((ctrl.deep_idle_request & button_input) | (btn_hold & ctrl.button_reset_enable));

  // Sequencer step terms
  wire slot_end = tick & (tmr >= `PSS_SLOT_MS - 14'h0001);
  wire [6:0] up_en = reg_enable | (tgt & slot_hits(startup_slot, slot));
  wire pup_done = (up_en & tgt) == tgt;
  wire dn_all = shutdown_slot == 21'h00_0000;
  wire [6:0] dn_en = dn_all ? (reg_enable & tgt)
                   : (reg_enable & ~(~tgt & slot_hits(shutdown_slot, slot)));
  wire pdn_done = (dn_en & ~tgt) == 7'h00;

  // Bus handshake: one wait cycle, then answer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end else begin
      avs_waitrequest <= ~req;
      avs_readdata <= req ? rd_mux : avs_readdata;
    end
  end

  // Configuration registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl <= `PSS_CTRL_RST;
      sleep_keep <= `PSS_KEEP_RST;
      stby_on <= `PSS_STBY_RST;
      startup_slot <= `PSS_SLOT_RST;
      shutdown_slot <= `PSS_SLOT_RST;
    end else begin
      if (wr && sel_ctrl) begin
        ctrl <= pss_ctrl_t'(wctrl[11:0]);
      end else if (st == ST_STORE) begin
        ctrl.storage_request <= 1'b0;
      end else if (st == ST_DEEP) begin
        ctrl.deep_idle_request <= 1'b0;
      end
      if (wr && sel_keep) begin
        sleep_keep <= wkeep[6:0];
      end
      if (wr && sel_stby) begin
        stby_on <= wstby[6:0];
      end
      if (wr && sel_start) begin
        startup_slot <= wstart[20:0];
      end
      if (wr && sel_shut) begin
        shutdown_slot <= wshut[20:0];
      end
    end
  end

  // Sticky done flags, set wins over write-one clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flags <= '0;
    end else begin
      flags <= ((wr && sel_flag) ? (flags & ~wflag[1:0]) : flags)
             | {powerdown_done_irq, powerup_done_irq};
    end
  end

  // Millisecond prescaler
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pre <= 32'h0000_0000;
    end else begin
      pre <= tick ? 32'h0000_0000 : pre + 32'h0000_0001;
    end
  end

  // Power-on debounce
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dcnt <= 14'h0000;
      pon <= 1'b0;
    end else if (power_on_input == pon) begin
      dcnt <= 14'h0000;
    end else if (dcnt >= db_ms(ctrl.power_on_debounce_sel)) begin
      pon <= power_on_input;
      dcnt <= 14'h0000;
    end else if (tick) begin
      dcnt <= dcnt + 14'h0001;
    end
  end

  // Press timers; a press must start with a fall seen in this state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pon_q <= 1'b0;
      btn_q <= 1'b0;
      chg_q <= 1'b1;
      pon_arm <= 1'b0;
      btn_arm <= 1'b0;
      pon_ms <= 14'h0000;
      btn_ms <= 14'h0000;
      st_q <= ST_OFF;
    end else begin
      pon_q <= pon;
      btn_q <= button_input;
      chg_q <= sense.charger_absent;
      st_q <= st;
      pon_arm <= entered ? 1'b0 : (pon_arm | pon_q);
      btn_arm <= entered ? 1'b0 : (btn_arm | btn_q);
      if (pon || !pon_arm) begin
        pon_ms <= pon_rise ? pon_ms : 14'h0000;
      end else if (tick && pon_ms != 14'h3FFF) begin
        pon_ms <= pon_ms + 14'h0001;
      end
      if (button_input || !btn_arm) begin
        btn_ms <= 14'h0000;
      end else if (tick && btn_ms != 14'h3FFF) begin
        btn_ms <= btn_ms + 14'h0001;
      end
    end
  end

  // Power-state machine and sequencers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= ST_OFF;
      dest <= ST_OFF;
      tgt <= 7'h00;
      slot <= 3'h0;
      tmr <= 14'h0000;
      from_off <= 1'b0;
      from_run <= 1'b0;
      off_by_lp <= 1'b0;
      reg_enable <= 7'h00;
      backup_rail_on <= 1'b0;
      host_reset_n <= 1'b0;
      powerup_done_irq <= 1'b0;
      powerdown_done_irq <= 1'b0;
    end else begin
      powerup_done_irq <= 1'b0;
      powerdown_done_irq <= 1'b0;
      backup_rail_on <= st != ST_STORE;
      if (tick && tmr != 14'h3FFF) begin
        tmr <= tmr + 14'h0001;
      end
      case (st)
        ST_OFF: begin
          host_reset_n <= 1'b0;
          if (pon) begin
            tmr <= 14'h0000;
          end
          if (ctrl.storage_request) begin
            if (sense.charger_absent) begin
              st <= ST_STORE;
            end
          end else if (deep_go) begin
            st <= ST_DEEP;
          end else if (turn_on) begin
            st <= ST_PUP;
            tgt <= 7'h7F;
            slot <= 3'h0;
            tmr <= 14'h0000;
            from_off <= 1'b1;
          end
        end
        ST_PUP: begin
          reg_enable <= up_en;
          if (pup_done) begin
            tmr <= 14'h0000;
            if (from_off) begin
              st <= ST_RLS;
            end else begin
              st <= ST_RUN;
              powerup_done_irq <= 1'b1;
            end
          end else if (slot_end) begin
            slot <= slot + 3'h1;
            tmr <= 14'h0000;
          end
        end
        ST_RLS: begin
          if (tmr >= rls_ms(ctrl.reset_release_delay)) begin
            host_reset_n <= 1'b1;
            st <= ST_RUN;
          end
        end
        ST_RUN, ST_STBY, ST_SLEEP: begin
          slot <= 3'h7;
          tmr <= 14'h0000;
          from_run <= st == ST_RUN;
          if (off_go) begin
            st <= ST_PDN;
            dest <= ST_OFF;
            tgt <= 7'h00;
            off_by_lp <= lp_off & ~ctrl.storage_request;
          end else if (st != ST_SLEEP && sleep_go) begin
            st <= ST_PDN;
            dest <= ST_SLEEP;
            tgt <= sleep_keep;
          end else if (st == ST_RUN && stby_req) begin
            st <= ST_PDN;
            dest <= ST_STBY;
            tgt <= stby_on;
          end else if ((st == ST_STBY && !stby_req) || (st == ST_SLEEP && wake)) begin
            st <= ST_PUP;
            tgt <= 7'h7F;
            slot <= 3'h0;
            from_off <= 1'b0;
          end
        end
        ST_PDN: begin
          reg_enable <= dn_en;
          if (pdn_done) begin
            st <= dest;
            tmr <= 14'h0000;
            powerdown_done_irq <= from_run && dest != ST_OFF;
            if (dest == ST_OFF) begin
              host_reset_n <= 1'b0;
            end
          end else if (slot_end) begin
            slot <= slot - 3'h1;
            tmr <= 14'h0000;
          end
        end
        ST_DEEP: begin
          if (btn_wake || chg_attach) begin
            st <= ST_OFF;
            off_by_lp <= 1'b0;
          end
        end
        ST_STORE: begin
          if (chg_attach || sense.battery_reattach) begin
            st <= ST_OFF;
            off_by_lp <= 1'b0;
          end
        end
        default: begin
          st <= ST_OFF;
        end
      endcase
    end
  end
endmodule : pss_sequencer

// *** tb/pss_sequencer_asserts.sv ***
// Port-level checks of the power-state sequencer
`timescale 1ns/1ns
module pss_sequencer_asserts
  import pss_pkg::*;
#(
  parameter int CYC_PER_MS = 25000,
  parameter logic [13:0] BTN_HOLD_MS = 14'h1F40
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Bus handshake
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  // Pins and outputs
  input wire logic watchdog_input,
  input wire logic [6:0] reg_enable,
  input wire logic backup_rail_on,
  input wire logic host_reset_n,
  input wire logic powerup_done_irq,
  input wire logic powerdown_done_irq
);
  localparam int GAP = CYC_PER_MS;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Named steps
  sequence bus_req_s;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence up_step_s;
    $changed(reg_enable) && reg_enable != 7'h00 && !host_reset_n;
  endsequence
  // Bus answers
  chk_bus_answer: assert property (bus_req_s |=> !avs_waitrequest)
    else $error("bus request not answered next cycle");
  chk_bus_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  // Done pulses
  chk_up_pulse: assert property (powerup_done_irq |-> host_reset_n ##1 !powerup_done_irq)
    else $error("powerup done pulse malformed");
  chk_dn_pulse: assert property (powerdown_done_irq |-> host_reset_n ##1 !powerdown_done_irq)
    else $error("powerdown done pulse malformed");
  // Off states, rails, sequencing gaps and watchdog off
  chk_store_dark: assert property (!backup_rail_on |-> reg_enable == 7'h00 && !host_reset_n)
    else $error("outputs active with backup rail off");
  chk_rail_first: assert property (reg_enable != 7'h00 |-> backup_rail_on)
    else $error("regulator on before backup rail");
  chk_slot_gap: assert property (up_step_s |=> $stable(reg_enable) [*8])
    else $error("sequencer steps too close");
  chk_release_gap: assert property ($rose(host_reset_n) |-> $past(reg_enable, GAP) == reg_enable)
    else $error("host released too soon after last regulator");
  chk_wdog_off: assert property (host_reset_n && !watchdog_input |-> ##[1:400] !host_reset_n)
    else $error("watchdog request did not turn off");
endmodule : pss_sequencer_asserts

bind pss_sequencer pss_sequencer_asserts #(.CYC_PER_MS(CYC_PER_MS), .BTN_HOLD_MS(BTN_HOLD_MS)) chk_u (
  .clk(clk), .rst(rst), .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
  .watchdog_input(watchdog_input), .reg_enable(reg_enable), .backup_rail_on(backup_rail_on),
  .host_reset_n(host_reset_n), .powerup_done_irq(powerup_done_irq), .powerdown_done_irq(powerdown_done_irq)
);

// *** tb/pss_host_model.sv ***
// Host processor model driving the watchdog pin
`timescale 1ns/1ns
module pss_host_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Host side
  input wire logic host_reset_n,
  input wire logic wd_req,
  // Pin toward the sequencer
  output logic watchdog_input
);
  // Pull low only while running, let go once held in reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      watchdog_input <= 1'b1;
    end else if (!host_reset_n) begin
      watchdog_input <= 1'b1;
    end else if (wd_req) begin
      watchdog_input <= 1'b0;
    end
  end
endmodule : pss_host_model

// *** tb/pss_sequencer_tb.sv ***
// Self-checking bench of the power-state sequencer
`timescale 1ns/1ns
`include "pss_map.svh"
module pss_sequencer_tb;
  import pss_pkg::*;
  localparam int CPM = 10;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic power_on_input = 1'b0;
  logic standby_input = 1'b0;
  logic wd_req = 1'b0;
  logic watchdog_input;
  pss_sense_t sense = 6'h1A;
  logic [6:0] reg_enable;
  logic backup_rail_on, host_reset_n, powerup_done_irq, powerdown_done_irq;
  logic [6:0] model_en = 7'h00;
  logic [6:0] prev_en = 7'h00;
  logic [31:0] sh = 32'h0;
  logic [31:0] rdq[$];
  logic [6:0] enq[$];
  int n_fail = 0, total_checks = 0, n_up = 0, n_dn = 0, tgt = 0, seed = 26;

  // Clock
  initial begin
    forever #20 clk = ~clk;
  end

  pss_sequencer #(.CYC_PER_MS(CPM), .BTN_HOLD_MS(14'h0005)) dut_u (
    .clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .power_on_input(power_on_input), .standby_input(standby_input),
    .watchdog_input(watchdog_input), .button_input(1'b1), .sense(sense), .reg_enable(reg_enable),
    .backup_rail_on(backup_rail_on), .host_reset_n(host_reset_n), .powerup_done_irq(powerup_done_irq),
    .powerdown_done_irq(powerdown_done_irq)
  );
  pss_host_model host_u (.clk(clk), .rst(rst), .host_reset_n(host_reset_n), .wd_req(wd_req),
    .watchdog_input(watchdog_input));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : conclude

  // One bus cycle, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (avs_waitrequest === 1'b0) break;
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (i == 50) begin
      n_fail++;
      conclude();
    end
  endtask : bus

  task automatic rd(input logic [4:0] a, input logic [31:0] exp);
    rdq.push_back(exp);
    bus(1'b0, a, 32'h0);
  endtask : rd

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  function automatic logic cond(input int k);
    case (k)
      0: return enq.size() == 0;
      1: return host_reset_n === 1'b1;
      2: return backup_rail_on === 1'b0;
      3: return backup_rail_on === 1'b1;
      4: return host_reset_n === 1'b0;
      5: return n_up >= tgt;
      default: return n_dn >= tgt;
    endcase
  endfunction : cond

  task automatic wait_for(input int k);
    for (int i = 0; i < 3000 && !cond(k); i++) @(posedge clk);
    if (!cond(k)) begin
      n_fail++;
      conclude();
    end
  endtask : wait_for

  // Expected enables, one step per regulator in index order
  task automatic push_up(input logic [6:0] m);
    for (int i = 0; i < 7; i++) begin
      if (m[i]) begin
        model_en[i] = 1'b1;
        enq.push_back(model_en);
      end
    end
  endtask : push_up

  // Expected enables, descending shutdown slots, ties together
  task automatic push_dn(input logic [6:0] m);
    logic [6:0] s;
    for (int t = 7; t >= 0; t--) begin
      s = 7'h00;
      for (int i = 0; i < 7; i++) begin
        if (m[i] && model_en[i] && sh[3*i+:3] == t) s[i] = 1'b1;
      end
      if (s != 7'h00) begin
        model_en = model_en & ~s;
        enq.push_back(model_en);
      end
    end
  endtask : push_dn

  // Compare enable changes and read answers with the oldest note
  always @(posedge clk) begin
    if (!rst && reg_enable !== prev_en) begin
      if (enq.size() == 0) check({25'h0, reg_enable}, 32'hFFFF_FFFF);
      else check({25'h0, reg_enable}, {25'h0, enq.pop_front()});
    end
    prev_en <= reg_enable;
    if (avs_read && avs_waitrequest === 1'b0) check(avs_readdata, rdq.pop_front());
    n_up <= n_up + int'(powerup_done_irq === 1'b1);
    n_dn <= n_dn + int'(powerdown_done_irq === 1'b1);
  end

  // Main sequence
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    check({backup_rail_on, reg_enable}, 32'h80);
    rd(`PSS_OFS_CTRL, 32'h0);
    rd(`PSS_OFS_STBY, 32'h7F);
    rd(`PSS_OFS_SHUT, 32'h001A_C688);
    rd(5'h1C, 32'h0);
    push_up(7'h7F);
    power_on_input <= 1'b1;
    wait_for(0);
    wait_for(1);
    rd(`PSS_OFS_STAT, 32'h0FF3);
    sh = $random(seed);
    wr(`PSS_OFS_SHUT, {11'h0, sh[20:0]});
    wr(`PSS_OFS_STBY, 32'h0);
    push_dn(7'h7F);
    standby_input <= 1'b1;
    tgt = 1;
    wait_for(0);
    wait_for(6);
    push_up(7'h7F);
    standby_input <= 1'b0;
    wait_for(0);
    wait_for(5);
    sh = 32'h0;
    wr(`PSS_OFS_SHUT, 32'h0);
    push_dn(7'h7F);
    wr(`PSS_OFS_CTRL, 32'h1);
    tgt = 2;
    wait_for(0);
    wait_for(6);
    push_up(7'h7F);
    standby_input <= 1'b1;
    wait_for(0);
    wait_for(5);
    wr(`PSS_OFS_STBY, 32'h7F);
    standby_input <= 1'b0;
    tgt = 3;
    wait_for(6);
    standby_input <= 1'b1;
    wait_for(5);
    push_dn(7'h7F);
    push_up(7'h7F);
    wd_req <= 1'b1;
    wait_for(4);
    wd_req <= 1'b0;
    wait_for(0);
    wait_for(1);
    push_dn(7'h7F);
    wr(`PSS_OFS_CTRL, 32'h0401);
    wait_for(2);
    wait_for(0);
    check(host_reset_n, 32'h0);
    rd(`PSS_OFS_STAT, 32'h0008);
    power_on_input <= 1'b0;
    repeat (2 * CPM) @(posedge clk);
    sense.charger_absent <= 1'b0;
    wait_for(3);
    rd(`PSS_OFS_STAT, 32'h0);
    rd(`PSS_OFS_FLAG, 32'h3);
    wr(`PSS_OFS_FLAG, 32'h3);
    rd(`PSS_OFS_FLAG, 32'h0);
    check(32'(n_up), 32'h3);
    check(32'(n_dn), 32'h3);
    conclude();
  end
endmodule : pss_sequencer_tb
